//--- src/lcdcd_top.sv
// Purpose: Host command decoder, display RAM and key scan of an LCD driver.
// Assumes: Host strobes are synchronous one-cycle pulses on REF_CLK_I.
// Notes:   Analog rails, waveform generator and pins beyond flags omitted.
`timescale 1ns/1ps
module lcdcd_top (
   // Clock and reset
   input  wire logic                    REF_CLK_I,
   input  wire logic                    RST_N_I,
   // Host port
   input  wire logic                    KEY_SEL_I,
   input  wire logic                    DATA_SEL_I,
   input  wire logic                    WR_I,
   input  wire logic                    RD_I,
   input  wire logic [7:0]              WDATA_I,
   output logic      [7:0]              RDATA_O,
   // Key matrix
   input  wire logic [3:0]              KEY_SENSE_N_I,
   output logic      [7:0]              KEY_DRIVE_O,
   output logic                         KEY_REQ_O,
   // Configuration outputs
   output lcdcd_pkg::lcdcd_level_t      DISPLAY_STATE_CMD_LEVEL_O,
   output logic                         DUTY_26_O,
   output logic      [4:0]              START_LINE_O,
   output logic      [3:0]              CONTRAST_O,
   output logic                         QUAD_EN_O,
   output logic                         OSC_EN_O,
   output logic                         OSC_EXT_O,
   output logic      [1:0]              PUMP_SEL_O
);
   import lcdcd_pkg::*;

   // Configuration state
   logic       display_state_cmd_on, display_state_cmd_act, word8, duty26, cnt_page, cnt_up;
   logic       quad_en, osc_en, osc_ext;
   logic [1:0] pump_sel;
   logic [3:0] contrast, page;
   logic [4:0] col, zline;
   logic       next_display_state_cmd_on, next_display_state_cmd_act, next_word8, next_duty26;
   logic       next_cnt_page, next_cnt_up, next_quad_en, next_osc_en;
   logic       next_osc_ext;
   logic [1:0] next_pump_sel;
   logic [3:0] next_contrast, next_page;
   logic [4:0] next_col, next_zline;
   logic       rst_seen;
   logic [3:0] page_max;
   logic       cmd_wr, data_acc;

   // Display RAM, one byte per page and column
   logic [7:0] ram [PAGE_CNT*COL_CNT];
   logic [8:0] ram_addr;

   // Key scan state
   lcdcd_ks_t  ks, next_ks;
   logic [4:0] div, next_div;
   logic [2:0] kcol, next_kcol;
   logic [1:0] hits, next_hits;
   logic       req, next_req;
   logic [3:0] ki_res, next_ki_res;
   logic [7:0] ko_res, next_ko_res;
   logic [7:0] rdata, next_rdata;
   logic       tick;

   assign page_max = word8 ? PAGE_MAX_8 : PAGE_MAX_6;
   assign cmd_wr   = WR_I && !KEY_SEL_I && !DATA_SEL_I;
   assign data_acc = (WR_I || RD_I) && !KEY_SEL_I && DATA_SEL_I;
   assign ram_addr = 9'(page * 9'(COL_CNT) + 9'(col));

   // Command decode and address counters
   always_comb begin
      next_display_state_cmd_on  = display_state_cmd_on;
      next_display_state_cmd_act = display_state_cmd_act;
      next_word8    = word8;
      next_duty26   = duty26;
      next_cnt_page = cnt_page;
      next_cnt_up   = cnt_up;
      next_quad_en  = quad_en;
      next_osc_en   = osc_en;
      next_osc_ext  = osc_ext;
      next_pump_sel = pump_sel;
      next_contrast = contrast;
      next_page     = page;
      next_col      = col;
      next_zline    = zline;
      if (cmd_wr) begin
         if ((WDATA_I & CMD_DISPLAY_STATE_CMD_MASK) == CMD_DISPLAY_STATE_CMD) begin
            next_display_state_cmd_on  = WDATA_I[1];
            next_display_state_cmd_act = WDATA_I[0];
         end else if ((WDATA_I & CMD_DISPLAY_STATE_CMD_MASK) == CMD_FMT) begin
            next_word8  = WDATA_I[1];
            next_duty26 = WDATA_I[0];
         end else if (WDATA_I == CMD_OSC_ON) begin
            next_osc_en = 1'b1;
         end else if (WDATA_I == CMD_OSC_OFF) begin
            next_osc_en = 1'b0;
         end else if (WDATA_I == CMD_OSCILLATOR_MODE_CMD_RC) begin
            next_osc_ext = 1'b0;
         end else if (WDATA_I == CMD_OSCILLATOR_MODE_CMD_EXT) begin
            next_osc_ext = 1'b1;
         end else if ((WDATA_I & CMD_DISPLAY_STATE_CMD_MASK) == CMD_PUMP) begin
            next_pump_sel = WDATA_I[1:0];
         end else if ((WDATA_I & CMD_CONTRAST_CMD_MASK) == CMD_CONTRAST_CMD) begin
            next_contrast = WDATA_I[3:0];
            next_quad_en  = WDATA_I[4];
         end else if ((WDATA_I & CMD_DISPLAY_STATE_CMD_MASK) == CMD_UDE) begin
            next_cnt_page = WDATA_I[1];
            next_cnt_up   = WDATA_I[0];
         end else if ((WDATA_I & CMD_PAGE_MASK) == CMD_PAGE) begin
            next_page = WDATA_I[3:0];
         end else if (WDATA_I >= CMD_ZMIN && WDATA_I <= CMD_ZMAX) begin
            next_zline = 5'(WDATA_I - CMD_ZMIN);
         end else if (WDATA_I >= CMD_XMIN && WDATA_I <= CMD_XMAX) begin
            next_col = WDATA_I[4:0];
         end
         // Other codes fall through unchanged
      end else if (data_acc) begin
         // Step the selected counter only
         if (cnt_page) begin
            if (cnt_up) begin
               next_page = (page >= page_max) ? 4'h0 : page + 4'h1;
            end else begin
               next_page = (page == 4'h0) ? page_max : page - 4'h1;
            end
         end else begin
            if (cnt_up) begin
               next_col = (col >= COL_MAX) ? 5'h00 : col + 5'h01;
            end else begin
               next_col = (col == 5'h00) ? COL_MAX : col - 5'h01;
            end
         end
      end
   end

   // Configuration registers with reset defaults
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         display_state_cmd_on  <= 1'b0;
         display_state_cmd_act <= 1'b0;
         word8    <= 1'b1;
         duty26   <= 1'b0;
         cnt_page <= 1'b1;
         cnt_up   <= 1'b1;
         quad_en  <= 1'b0;
         osc_en   <= 1'b1;
         osc_ext  <= 1'b0;
         pump_sel <= PUMP_HALF;
         contrast <= CONTRAST_CMD_RST;
         page     <= 4'h0;
         col      <= 5'h00;
         zline    <= 5'h00;
         rst_seen <= 1'b1;
      end else begin
         display_state_cmd_on  <= next_display_state_cmd_on;
         display_state_cmd_act <= next_display_state_cmd_act;
         word8    <= next_word8;
         duty26   <= next_duty26;
         cnt_page <= next_cnt_page;
         cnt_up   <= next_cnt_up;
         quad_en  <= next_quad_en;
         osc_en   <= next_osc_en;
         osc_ext  <= next_osc_ext;
         pump_sel <= next_pump_sel;
         contrast <= next_contrast;
         page     <= next_page;
         col      <= next_col;
         zline    <= next_zline;
         rst_seen <= 1'b0;
      end
   end

   // Display RAM write port, no reset on contents
   always_ff @(posedge REF_CLK_I) begin
      if (WR_I && !KEY_SEL_I && DATA_SEL_I) begin
         ram[ram_addr] <= WDATA_I;
      end
   end

   // Key check divider: one tick per KEY_DIV clocks
   assign tick = (div == 5'(KEY_DIV - 1));

   // Key scan sequencer
   always_comb begin
      next_ks     = ks;
      next_div    = div + 5'h01;
      next_kcol   = kcol;
      next_hits   = hits;
      next_req    = req;
      next_ki_res = ki_res;
      next_ko_res = ko_res;
      // Press detection on three consecutive checks
      if (tick) begin
         if (KEY_SENSE_N_I != 4'hF) begin
            if (hits == 2'(KEY_HITS - 1)) begin
               next_req = 1'b1;
            end else begin
               next_hits = hits + 2'h1;
            end
         end else begin
            next_hits = 2'h0;
            next_req  = 1'b0;
         end
      end
      case (ks)
         LCDCD_KS_IDLE: begin
            // Key output read starts a scan
            if (RD_I && KEY_SEL_I && DATA_SEL_I) begin
               next_ks     = LCDCD_KS_SCAN;
               next_kcol   = 3'h0;
               next_ki_res = 4'h0;
               next_ko_res = 8'h00;
            end
         end
         LCDCD_KS_SCAN: begin
            if (tick) begin
               // Latch lines pulled low by the driven column
               if (KEY_SENSE_N_I != 4'hF) begin
                  next_ki_res = ki_res | ~KEY_SENSE_N_I;
                  next_ko_res = ko_res | (8'h01 << kcol);
               end
               if (kcol == 3'(KEY_COLS - 1)) begin
                  next_ks = LCDCD_KS_DONE;
               end else begin
                  next_kcol = kcol + 3'h1;
               end
            end
         end
         LCDCD_KS_DONE: begin
            next_ks = LCDCD_KS_IDLE;
         end
         default: begin
            next_ks = LCDCD_KS_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ks     <= LCDCD_KS_IDLE;
         div    <= 5'h00;
         kcol   <= 3'h0;
         hits   <= 2'h0;
         req    <= 1'b0;
         ki_res <= 4'h0;
         ko_res <= 8'h00;
      end else begin
         ks     <= next_ks;
         div    <= next_div;
         kcol   <= next_kcol;
         hits   <= next_hits;
         req    <= next_req;
         ki_res <= next_ki_res;
         ko_res <= next_ko_res;
      end
   end

   // Read data mux, answered the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (RD_I) begin
         if (!KEY_SEL_I && !DATA_SEL_I) begin
            next_rdata = {1'b0, word8, display_state_cmd_on, rst_seen,
                          2'b00, cnt_page, cnt_up};
         end else if (!KEY_SEL_I && DATA_SEL_I) begin
            next_rdata = ram[ram_addr];
         end else if (KEY_SEL_I && !DATA_SEL_I) begin
            next_rdata = {2'b00, ks != LCDCD_KS_IDLE,
                          req, ki_res};
         end else begin
            next_rdata = ko_res;
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Outputs
   assign RDATA_O      = rdata;
   assign KEY_REQ_O    = req;
   assign KEY_DRIVE_O  = (ks == LCDCD_KS_SCAN) ? (8'h01 << kcol) : 8'h00;
   // Standby forces ground, else off or on waveform
   assign DISPLAY_STATE_CMD_LEVEL_O = !display_state_cmd_act ? LCDCD_LVL_VSS :
                         (display_state_cmd_on ? LCDCD_LVL_ON : LCDCD_LVL_OFF);
   assign DUTY_26_O    = duty26;
   assign START_LINE_O = zline;
   assign CONTRAST_O   = contrast;
   assign QUAD_EN_O    = quad_en;
   assign OSC_EN_O     = osc_en;
   assign OSC_EXT_O    = osc_ext;
   assign PUMP_SEL_O   = pump_sel;
endmodule

//--- src/lcdcd_pkg.sv
// Purpose: Constants for the LCD driver command decoder.
// Assumes: Byte-wide host port, one clock at 10 MHz.
// Notes:   Function
// Function
// - standby forces outputs to ground; active gives off or on waveform
// - format select bit 1 picks 8-bit (1) or 6-bit (0) words
// - format select bit 0 picks 1/26 (1) or 1/18 (0) duty
// - reset gives 8-bit words, 1/18 duty, page counter counting up
// - reset clears page, column and start-line addresses
// - reset: oscillator on, RC mode, quadrupler off, pump at half rate
// - counter mode bit 1 picks page/column, bit 0 picks up/down
// - only the selected counter steps after each data access
// - page command loads low four bits as page address
// - start-line command loads row 0 to 25 as first screen line
// - column command loads low five bits, range 0 to 25
// - contrast command stores 16-level setting, reset is lightest
// - contrast bit 4 drives the voltage quadrupler enable
// - 0x11 starts and 0x10 stops the oscillator clock
// - 0x20 selects RC oscillator, 0x21 external clock
// - pump clock codes 0x40..0x43 pick half, quarter, eighth, full
// - status read packs word length, display on, reset, counter flags
// - data select high writes or reads display RAM at current address
// - key input read returns busy, request and four key sense bits
// - key request flag follows key presses and drives an output pin
// - scan sets each key sense bit whose line saw a pressed key
// - display command bit 1 is display-on, bit 0 display-active
// - column wraps 0..25, page wraps 0..9 or 0..13
// - key output read starts a scan; first result is a dummy

package lcdcd_pkg;
   // Command codes and masks
   localparam logic [7:0] CMD_DISPLAY_STATE_CMD_MASK  = 8'hFC;
   localparam logic [7:0] CMD_DISPLAY_STATE_CMD       = 8'h00;
   localparam logic [7:0] CMD_FMT        = 8'h08;
   localparam logic [7:0] CMD_OSC_OFF    = 8'h10;
   localparam logic [7:0] CMD_OSC_ON     = 8'h11;
   localparam logic [7:0] CMD_OSCILLATOR_MODE_CMD_RC    = 8'h20;
   localparam logic [7:0] CMD_OSCILLATOR_MODE_CMD_EXT   = 8'h21;
   localparam logic [7:0] CMD_PUMP       = 8'h40;
   localparam logic [7:0] CMD_CONTRAST_CMD_MASK  = 8'hE0;
   localparam logic [7:0] CMD_CONTRAST_CMD       = 8'h60;
   localparam logic [7:0] CMD_UDE        = 8'h80;
   localparam logic [7:0] CMD_PAGE_MASK  = 8'hF0;
   localparam logic [7:0] CMD_PAGE       = 8'hE0;
   localparam logic [7:0] CMD_ZMIN       = 8'hA0;
   localparam logic [7:0] CMD_ZMAX       = 8'hB9;
   localparam logic [7:0] CMD_XMIN       = 8'hC0;
   localparam logic [7:0] CMD_XMAX       = 8'hD9;
   // Address limits
   localparam logic [4:0] COL_MAX        = 5'h19;
   localparam logic [3:0] PAGE_MAX_8     = 4'h9;
   localparam logic [3:0] PAGE_MAX_6     = 4'hD;
   localparam int         PAGE_CNT       = 14;
   localparam int         COL_CNT        = 26;
   // Pump clock selections
   localparam logic [1:0] PUMP_HALF      = 2'h0;
   // Reset values
   localparam logic [3:0] CONTRAST_CMD_RST       = 4'h0;
   // Key scan timing: key check rate is oscillator / 32
   localparam int         KEY_DIV        = 32;
   localparam int         KEY_HITS       = 3;
   localparam int         KEY_COLS       = 8;
   // Display output levels
   typedef enum logic [1:0] {
      LCDCD_LVL_VSS = 2'b00,
      LCDCD_LVL_OFF = 2'b01,
      LCDCD_LVL_ON  = 2'b11
   } lcdcd_level_t;
   // Key scan states, Gray from idle through scan to done
   typedef enum logic [1:0] {
      LCDCD_KS_IDLE = 2'b00,
      LCDCD_KS_SCAN = 2'b01,
      LCDCD_KS_DONE = 2'b11
   } lcdcd_ks_t;
endpackage

//--- tb/lcdcd_chk_sva.sv
// Purpose: Concurrent checks on the decoder's command port
// Assumes: Host strobes are single-cycle pulses on REF_CLK_I
// Notes:   Attached by bind from the testbench top
`timescale 1ns/1ps
module lcdcd_chk (
   // Clock, reset and host port
   input wire logic                   REF_CLK_I,
   input wire logic                   RST_N_I,
   input wire logic                   KEY_SEL_I,
   input wire logic                   DATA_SEL_I,
   input wire logic                   WR_I,
   input wire logic                   RD_I,
   input wire logic [7:0]             WDATA_I,
   // Observed outputs
   input wire logic [7:0]             RDATA_O,
   input wire lcdcd_pkg::lcdcd_level_t DISPLAY_STATE_CMD_LEVEL_O,
   input wire logic                   DUTY_26_O,
   input wire logic [4:0]             START_LINE_O,
   input wire logic [3:0]             CONTRAST_O,
   input wire logic                   QUAD_EN_O,
   input wire logic                   OSC_EN_O,
   input wire logic                   OSC_EXT_O,
   input wire logic [1:0]             PUMP_SEL_O
);
   import lcdcd_pkg::*;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // A command write whose code lies in lo..hi
   sequence s_cmd(logic [7:0] lo, logic [7:0] hi);
      WR_I && !KEY_SEL_I && !DATA_SEL_I && WDATA_I >= lo && WDATA_I <= hi;
   endsequence
   // Read data only stand in the cycle after a read
   a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data outside read slot");
   a_display_state_cmd_state: assert property ((s_cmd(8'h00, 8'h03) ##0
      WDATA_I[1:0] != 2'h2) |=> DISPLAY_STATE_CMD_LEVEL_O == $past(WDATA_I[1:0]))
      else $error("display level differs from command");
   a_duty_sel: assert property (s_cmd(8'h08, 8'h0B)
      |=> DUTY_26_O == $past(WDATA_I[0])) else $error("duty bad");
   a_contrast_set: assert property (s_cmd(8'h60, 8'h7F)
      |=> CONTRAST_O == $past(WDATA_I[3:0])
      && QUAD_EN_O == $past(WDATA_I[4])) else $error("contrast bad");
   a_osc_enable: assert property (s_cmd(8'h10, 8'h11)
      |=> OSC_EN_O == $past(WDATA_I[0])) else $error("osc enable bad");
   a_osc_mode: assert property (s_cmd(8'h20, 8'h21)
      |=> OSC_EXT_O == $past(WDATA_I[0])) else $error("osc mode bad");
   a_pump_sel: assert property (s_cmd(8'h40, 8'h43)
      |=> PUMP_SEL_O == $past(WDATA_I[1:0])) else $error("pump bad");
   a_start_line: assert property (s_cmd(8'hA0, 8'hB9)
      |=> START_LINE_O == $past(WDATA_I[4:0])) else $error("start bad");
   a_cfg_hold: assert property ((!WR_I || KEY_SEL_I || DATA_SEL_I)
      |=> $stable(CONTRAST_O) && $stable(START_LINE_O)
      && $stable(DUTY_26_O)) else $error("config moved without command");
endmodule

//--- tb/lcdcd_keypad.sv
// Purpose: Key matrix with pull-ups on the sense lines
// Assumes: Idle scan outputs all sit low, so any key pulls its line
// Notes:   pressed_i bit line*8+column marks a held key
`timescale 1ns/1ps
module lcdcd_keypad (
   // Scan drive and key table
   input  wire logic [7:0]  drive_i,
   input  wire logic [31:0] pressed_i,
   // Sense lines, active low
   output logic      [3:0]  sense_n_o
);
   logic [7:0] cols;
   // Released lines rise through the pull-up
   always_comb begin
      cols = (drive_i == 8'h00) ? 8'hFF : drive_i;
      for (int i = 0; i < 4; i++) begin
         sense_n_o[i] = ~|(pressed_i[i*8 +: 8] & cols);
      end
   end
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench for the LCD command decoder
// Assumes: Bench acts as host, keypad model on the key lines
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
module testbench;
   import lcdcd_pkg::*;
   logic clk, rst_n, ksel, dsel, wr, rd, quad, oen, oext, req, duty;
   logic [7:0] wdata, rdata, kdrv, v;
   logic [4:0] sline;
   logic [3:0] contrast_cmd, ksn;
   logic [1:0] pump;
   logic [31:0] pressed;
   lcdcd_level_t lvl;
   int n_errors, samples_checked;
   lcdcd_top dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .KEY_SEL_I(ksel),
      .DATA_SEL_I(dsel), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata),
      .RDATA_O(rdata), .KEY_SENSE_N_I(ksn), .KEY_DRIVE_O(kdrv),
      .KEY_REQ_O(req), .DISPLAY_STATE_CMD_LEVEL_O(lvl), .DUTY_26_O(duty),
      .START_LINE_O(sline), .CONTRAST_O(contrast_cmd), .QUAD_EN_O(quad),
      .OSC_EN_O(oen), .OSC_EXT_O(oext), .PUMP_SEL_O(pump));
   lcdcd_keypad u_keys (.drive_i(kdrv), .pressed_i(pressed),
      .sense_n_o(ksn));
   // Clock at 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr8(input logic k, d, input logic [7:0] b);
      @(posedge clk);
      ksel <= k;
      dsel <= d;
      wdata <= b;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd8(input logic k, d);
      @(posedge clk);
      ksel <= k;
      dsel <= d;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Reset values and the one-shot reset flag in status
   task automatic t_reset();
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("status rst", rdata, 8'h53);
      rd8(0, 0);
      chk("status", v, 8'h43);
      chk("cfg", {lvl, duty, quad, contrast_cmd}, 8'h00);
      chk("osc", {oen, oext, pump}, 8'h08);
      chk("start", sline, 8'h00);
      wr8(0, 1, 8'h5A);
      wr8(0, 0, 8'hE0);
      rd8(0, 1);
      chk("ram 0 0", v, 8'h5A);
      $display("reset test done");
   endtask
   // Display state, format and the plain settings
   task automatic t_cfg();
      logic [7:0] c[3] = '{8'h00, 8'h01, 8'h03};
      for (int i = 0; i < 3; i++) begin
         wr8(0, 0, c[i]);
         chk("level", lvl, c[i][1:0]);
         rd8(0, 0);
         chk("status on", v, {2'b01, c[i][1], 5'b00011});
      end
      for (int i = 0; i < 4; i++) begin
         wr8(0, 0, 8'h08 + i[7:0]);
         rd8(0, 0);
         chk("duty", {7'h00, duty}, {7'h00, i[0]});
         chk("fmt", v, {1'b0, i[1], 6'b100011});
      end
      wr8(0, 0, 8'h7F);
      chk("contrast_cmd", {quad, contrast_cmd}, 8'h1F);
      wr8(0, 0, 8'h65);
      chk("contrast_cmd", {quad, contrast_cmd}, 8'h05);
      wr8(0, 0, 8'h10);
      chk("osc off", oen, 8'h00);
      wr8(0, 0, 8'h11);
      wr8(0, 0, 8'h21);
      chk("osc", {oen, oext}, 8'h03);
      wr8(0, 0, 8'h20);
      chk("osc rc", oext, 8'h00);
      for (int i = 3; i >= 0; i--) begin
         wr8(0, 0, 8'h40 + i[7:0]);
         chk("pump", pump, i[7:0]);
      end
      wr8(0, 0, 8'hB9);
      chk("start", sline, 8'h19);
      wr8(0, 0, 8'hA0);
      chk("start", sline, 8'h00);
      $display("config test done");
   endtask
   // Address counters, wrap and undefined codes
   task automatic t_ram();
      logic [7:0] e[7] = '{8'hAA, 8'hBB, 8'hCC, 8'hCC, 8'hBB, 8'hAA, 8'h22};
      wr8(0, 0, 8'h81);
      rd8(0, 0);
      chk("status x", v, 8'h61);
      wr8(0, 0, 8'hE3);
      wr8(0, 0, 8'hD8);
      for (int i = 0; i < 3; i++) wr8(0, 1, e[i]);
      wr8(0, 0, 8'hD8);
      for (int i = 0; i < 3; i++) begin
         rd8(0, 1);
         chk("x up", v, e[i]);
      end
      wr8(0, 0, 8'h80);
      wr8(0, 0, 8'hC0);
      wr8(0, 0, 8'hF5);
      wr8(0, 0, 8'h30);
      wr8(1, 0, 8'hC1);
      for (int i = 3; i < 6; i++) begin
         rd8(0, 1);
         chk("x down", v, e[i]);
      end
      wr8(0, 0, 8'h83);
      wr8(0, 0, 8'hE9);
      wr8(0, 0, 8'hC0);
      wr8(0, 1, 8'h11);
      wr8(0, 1, 8'h22);
      wr8(0, 0, 8'h82);
      wr8(0, 0, 8'hE0);
      rd8(0, 1);
      chk("y wrap", v, 8'h22);
      rd8(0, 1);
      chk("y wrap", v, 8'h11);
      $display("ram test done");
   endtask
   // Key scan with keys on line 1, columns 2 and 5
   task automatic t_key();
      pressed <= 32'h0000_2400;
      rd8(1, 1);
      chk("dummy", v, 8'h00);
      chk("drive", kdrv, 8'h01);
      rd8(1, 0);
      chk("busy", v[5], 8'h01);
      for (int n = 0; n < 60 && v[5]; n++) begin
         repeat (10) @(posedge clk);
         rd8(1, 0);
      end
      repeat (150) @(posedge clk);
      rd8(1, 0);
      chk("key in", v, 8'h12);
      chk("req on", {7'h00, req}, 8'h01);
      rd8(1, 1);
      chk("key out", v, 8'h24);
      pressed <= 32'h0;
      repeat (600) @(posedge clk);
      chk("req off", req, 8'h00);
      $display("key test done");
   endtask
   initial begin
      {rst_n, ksel, dsel, wr, rd, wdata, pressed} = '0;
      n_errors = 0;
      samples_checked = 0;
      t_reset();
      t_cfg();
      t_ram();
      t_key();
      results();
   end
   // Watchdog well beyond the expected run
   initial begin
      #1000000;
      n_errors++;
      results();
   end
endmodule
bind lcdcd_top lcdcd_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
   .KEY_SEL_I(KEY_SEL_I), .DATA_SEL_I(DATA_SEL_I), .WR_I(WR_I),
   .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
   .DISPLAY_STATE_CMD_LEVEL_O(DISPLAY_STATE_CMD_LEVEL_O), .DUTY_26_O(DUTY_26_O),
   .START_LINE_O(START_LINE_O), .CONTRAST_O(CONTRAST_O),
   .QUAD_EN_O(QUAD_EN_O), .OSC_EN_O(OSC_EN_O), .OSC_EXT_O(OSC_EXT_O),
   .PUMP_SEL_O(PUMP_SEL_O));
